// [hw/asf_status_target.sv]
// converter status register, command decode and i2c target top
module asf_status_target #(
  parameter logic [2:0] ADDR_UPPER = asf_pkg::ADDR_BASE // fixed address part
) (
  input wire logic clk, // system clock, 125 MHz
  input wire logic rst, // async reset, active high
  input wire logic scl_in, // bus clock pin level
  input wire logic sda_in, // bus data pin level
  output logic sda_out, // data pin drive level, always low
  output logic sda_oe, // high while pulling data line low
  output logic scl_out, // clock pin drive level, always low
  output logic scl_oe, // clock drive enable, never high
  input wire logic [1:0] addr_select_pin_low, // strap code of low pin
  input wire logic [1:0] addr_select_pin_high, // strap code of high pin
  input wire logic result_valid, // pulse: converter has a new result
  input wire logic [23:0] result_data, // new result value
  output logic result_ready_n_out, // data-ready pin level, always low
  output logic result_ready_n_oe, // high while pulling data-ready low
  output logic [7:0] config_out, // configuration register contents
  output logic start_pulse, // pulse: start or sync command
  output logic powerdown_pulse, // pulse: power-down command
  output logic soft_reset_pulse // pulse: reset command
);
  typedef enum logic [1:0] {SRC_NONE, SRC_DATA, SRC_REG} asf_src_t;
  logic [1:0] pin_low_s1_reg, pin_low_s2_reg; // strap sync chain
  logic [1:0] pin_high_s1_reg, pin_high_s2_reg; // strap sync chain
  logic [6:0] addr_reg; // own target address
  logic addr_taken_reg; // strap captured since reset
  logic result_ready_flag_reg; // status bit 7
  logic [23:0] result_reg; // latest result from converter
  logic [23:0] out_shift_reg; // bytes on their way to the host
  asf_src_t src_reg; // what a read returns
  logic [1:0] reg_sel_reg; // register picked by last command
  logic cmd_phase_reg; // next written byte is a command
  logic wdata_phase_reg; // next written byte is register data
  logic data_first_reg; // first data byte not yet sent
  logic [7:0] config_reg; // configuration register
  logic [7:0] rx_data; // byte from target engine
  logic rx_valid, wr_start, rd_start, tx_load; // target engine events
  logic tgt_sda_oe; // data drive from target engine
  logic [7:0] tx_data; // byte offered to the engine
  logic data_read; // conversion data leaves the device
  logic is_rdata, is_read_register_command, is_write_register_command; // command decode

  // register address field of a command
  function automatic logic [1:0] cmd_reg(input logic [7:0] cmd);
    cmd_reg = cmd[asf_pkg::READ_REGISTER_COMMAND_ADDR_LSB +: 2];
  endfunction

  // status byte as read by the host
  function automatic logic [7:0] status_byte(input logic flag);
    status_byte = {flag, asf_pkg::RESERVED_VALUE};
  endfunction

  // ************************************************************
  // bit engine
  // ************************************************************
  asf_i2c_target u_tgt (
    .clk(clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .own_addr(addr_reg),
    .tx_data(tx_data),
    .sda_oe(tgt_sda_oe),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .wr_start(wr_start),
    .rd_start(rd_start),
    .tx_load(tx_load)
  );

  assign sda_oe = tgt_sda_oe;

  // ************************************************************
  // fixed pin drives
  // ************************************************************
  // open-drain levels; clock line is left to the controller
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      result_ready_n_out <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      result_ready_n_out <= 1'b0;
    end
  end

  // ************************************************************
  // address straps
  // ************************************************************
  // strap codes pass two flops; kept out of reset so the chain
  // already holds the pin codes when reset lets go
  always_ff @(posedge clk)
  begin
    pin_low_s1_reg <= addr_select_pin_low;
    pin_low_s2_reg <= pin_low_s1_reg;
    pin_high_s1_reg <= addr_select_pin_high;
    pin_high_s2_reg <= pin_high_s1_reg;
  end

  // address caught once, at the first edge after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_reg <= 7'h00;
      addr_taken_reg <= 1'b0;
    end
    else
    begin
      if (!addr_taken_reg)
      begin
        // four codes per pin give sixteen addresses
        addr_reg <= {ADDR_UPPER, pin_high_s2_reg, pin_low_s2_reg};
        addr_taken_reg <= 1'b1;
      end
    end
  end

  // ************************************************************
  // command decode
  // ************************************************************
  assign is_rdata = rx_data == asf_pkg::CMD_RDATA;
  assign is_read_register_command = (rx_data & asf_pkg::CMD_READ_REGISTER_COMMAND_MASK)
                   == asf_pkg::CMD_READ_REGISTER_COMMAND_CODE;
  assign is_write_register_command = (rx_data & asf_pkg::CMD_WRITE_REGISTER_COMMAND_MASK)
                   == asf_pkg::CMD_WRITE_REGISTER_COMMAND_CODE;
  assign data_read = tx_load && src_reg == SRC_DATA && data_first_reg;

  // read byte source: result bytes msb first, or one register
  always_comb
  begin
    tx_data = 8'hff;
    case (src_reg)
      SRC_DATA: tx_data = out_shift_reg[23:16];
      SRC_REG:
      begin
        if (reg_sel_reg == asf_pkg::STATUS_ADDR)
          tx_data = status_byte(result_ready_flag_reg);
        else if (reg_sel_reg == asf_pkg::CONFIG_ADDR)
          tx_data = config_reg;
        else
          tx_data = 8'h00;
      end
      default: tx_data = 8'hff;
    endcase
  end

  // ************************************************************
  // transfer sequencing
  // ************************************************************
  // tracks command and data phases and the read source
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_phase_reg <= 1'b0;
      wdata_phase_reg <= 1'b0;
      src_reg <= SRC_NONE;
      reg_sel_reg <= 2'h0;
      data_first_reg <= 1'b0;
      out_shift_reg <= 24'h000000;
    end
    else
    begin
      if (wr_start)
      begin
        cmd_phase_reg <= 1'b1;
        wdata_phase_reg <= 1'b0;
      end
      else if (rx_valid && cmd_phase_reg)
      begin
        cmd_phase_reg <= 1'b0;
        if (is_rdata)
        begin
          // result enters the shifter only here
          out_shift_reg <= result_reg;
          src_reg <= SRC_DATA;
          data_first_reg <= 1'b1;
        end
        else if (is_read_register_command)
        begin
          src_reg <= SRC_REG;
          reg_sel_reg <= cmd_reg(rx_data);
        end
        else if (is_write_register_command)
        begin
          wdata_phase_reg <= 1'b1;
          reg_sel_reg <= cmd_reg(rx_data);
        end
      end
      else if (rx_valid)
        wdata_phase_reg <= 1'b0;
      if (tx_load && src_reg == SRC_DATA)
      begin
        // next result byte; zeros after the last one
        out_shift_reg <= {out_shift_reg[15:0], 8'h00};
        data_first_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // configuration register and command pulses
  // ************************************************************
  // only address zero is writable; status ignores writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      config_reg <= asf_pkg::CONFIG_RESET;
      start_pulse <= 1'b0;
      powerdown_pulse <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      start_pulse <= rx_valid && cmd_phase_reg
                     && rx_data == asf_pkg::CMD_START;
      powerdown_pulse <= rx_valid && cmd_phase_reg
                         && rx_data == asf_pkg::CMD_POWERDOWN;
      soft_reset_pulse <= rx_valid && cmd_phase_reg
                          && rx_data == asf_pkg::CMD_RESET;
      if (rx_valid && cmd_phase_reg && rx_data == asf_pkg::CMD_RESET)
        config_reg <= asf_pkg::CONFIG_RESET;
      else if (rx_valid && wdata_phase_reg
               && reg_sel_reg == asf_pkg::CONFIG_ADDR)
        config_reg <= rx_data;
    end
  end

  assign config_out = config_reg;

  // ************************************************************
  // result ready flag
  // ************************************************************
  // a new result wins over a read in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      result_ready_flag_reg <= asf_pkg::STATUS_RESET[asf_pkg::FLAG_POS];
      result_reg <= 24'h000000;
      result_ready_n_oe <= 1'b0;
    end
    else
    begin
      if (result_valid)
      begin
        result_ready_flag_reg <= 1'b1;
        result_reg <= result_data;
      end
      else if (data_read)
        result_ready_flag_reg <= 1'b0;
      // pin pulled low while a result waits
      result_ready_n_oe <= result_ready_flag_reg;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_status_cmd;
    rx_valid && cmd_phase_reg && is_read_register_command
    && cmd_reg(rx_data) == asf_pkg::STATUS_ADDR;
  endsequence

  sequence s_status_load;
    ##[1:1000] (tx_load && src_reg == SRC_REG);
  endsequence

  a_flag_sets: assert property (@(posedge clk) disable iff (rst)
    result_valid |=> result_ready_flag_reg ##1 result_ready_n_oe)
    else $error("ready flag not set by new result");
  a_flag_clears: assert property (@(posedge clk) disable iff (rst)
    data_read && !result_valid |=> !result_ready_flag_reg)
    else $error("ready flag not cleared by data read");
  a_reset_zero: assert property (@(posedge clk)
    $fell(rst) |-> !result_ready_flag_reg && !result_ready_n_oe)
    else $error("status not zero after reset");
  a_clock_free: assert property (@(posedge clk) disable iff (rst)
    !scl_oe)
    else $error("clock line driven");
  a_addr_map: assert property (@(posedge clk) disable iff (rst)
    $rose(addr_taken_reg) |-> addr_reg[6:4] == ADDR_UPPER
    && addr_reg[3:0] == {$past(pin_high_s2_reg), $past(pin_low_s2_reg)})
    else $error("target address not from straps");
  a_result_ready_flag_pin: assert property (@(posedge clk) disable iff (rst)
    result_ready_n_oe == $past(result_ready_flag_reg) && !result_ready_n_out)
    else $error("data-ready pin not open-drain copy of flag");
  a_addr_ack: assert property (@(posedge clk) disable iff (rst)
    (wr_start || rd_start) |-> tgt_sda_oe)
    else $error("address not acknowledged");
  a_status_read: assert property (@(posedge clk) disable iff (rst)
    s_status_cmd ##1 ((!rx_valid && !wr_start) throughout s_status_load)
    |-> tx_data == status_byte(result_ready_flag_reg))
    else $error("status read returned wrong byte");
  a_shift_hold: assert property (@(posedge clk) disable iff (rst)
    result_valid && !(rx_valid && cmd_phase_reg) && !tx_load
    |=> $stable(out_shift_reg))
    else $error("new result disturbed transfer");
  a_status_ro: assert property (@(posedge clk) disable iff (rst)
    rx_valid && wdata_phase_reg && reg_sel_reg == asf_pkg::STATUS_ADDR
    && !result_valid && !data_read
    |=> $stable(result_ready_flag_reg) && $stable(config_reg))
    else $error("write changed status");
endmodule

// [hw/asf_pkg.sv]
// constants shared by the result-ready status block and its i2c target
package asf_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [1:0] CONFIG_ADDR = 2'h0; // configuration register
  localparam logic [1:0] STATUS_ADDR = 2'h1; // conversion_status register
  localparam logic [7:0] CONFIG_RESET = 8'h00; // configuration after reset
  localparam logic [7:0] STATUS_RESET = 8'h00; // status after reset
  localparam int FLAG_POS = 7; // result_ready_flag bit position
  localparam logic [6:0] RESERVED_VALUE = 7'h00; // reserved bits read value
  // ************************************************************
  // command bytes
  // ************************************************************
  localparam logic [7:0] CMD_RESET = 8'h06; // soft reset
  localparam logic [7:0] CMD_START = 8'h08; // start or sync conversion
  localparam logic [7:0] CMD_POWERDOWN = 8'h02; // enter power-down
  localparam logic [7:0] CMD_RDATA = 8'h10; // read conversion data
  localparam logic [7:0] CMD_READ_REGISTER_COMMAND_MASK = 8'hf8; // read_register_command
  localparam logic [7:0] CMD_READ_REGISTER_COMMAND_CODE = 8'h20; // 0010 0rxx
  localparam logic [7:0] CMD_WRITE_REGISTER_COMMAND_MASK = 8'hf0; // write_register_command
  localparam logic [7:0] CMD_WRITE_REGISTER_COMMAND_CODE = 8'h40; // 0100 rrxx
  localparam int READ_REGISTER_COMMAND_ADDR_LSB = 2; // register address field of commands
  // ************************************************************
  // i2c addressing
  // ************************************************************
  localparam logic [2:0] ADDR_BASE = 3'h4; // upper target address bits
  localparam int DATA_BYTES = 3; // bytes of one conversion result
endpackage

// [hw/asf_i2c_target.sv]
// bit-level i2c target: start, stop, address match, byte shift and ack
module asf_i2c_target (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic scl_in, // bus clock pin level
  input wire logic sda_in, // bus data pin level
  input wire logic [6:0] own_addr, // target address
  input wire logic [7:0] tx_data, // byte to send on next load
  output logic sda_oe, // high pulls data line low
  output logic [7:0] rx_data, // received byte
  output logic rx_valid, // pulse: rx_data holds a written byte
  output logic wr_start, // pulse: address matched, write direction
  output logic rd_start, // pulse: address matched, read direction
  output logic tx_load // pulse: tx_data taken into shifter
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WRX, ST_WACK, ST_TX, ST_RACK, ST_RNEXT
  } asf_tgt_state_t;
  asf_tgt_state_t state_reg; // bus state
  logic [2:0] scl_sync_reg; // sync pair plus edge history
  logic [2:0] sda_sync_reg; // sync pair plus edge history
  logic [7:0] shift_reg; // byte shifter
  logic [3:0] cnt_reg; // bits done in current byte
  logic read_reg; // direction of current transfer
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // ************************************************************
  // pin sampling
  // ************************************************************
  // two flops before use, third for edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  assign scl_rise = scl_sync_reg[1] && !scl_sync_reg[2];
  assign scl_fall = !scl_sync_reg[1] && scl_sync_reg[2];
  assign start_cond = scl_sync_reg[1] && scl_sync_reg[2]
                      && !sda_sync_reg[1] && sda_sync_reg[2];
  assign stop_cond = scl_sync_reg[1] && scl_sync_reg[2]
                     && sda_sync_reg[1] && !sda_sync_reg[2];

  // ************************************************************
  // bus state machine
  // ************************************************************
  // data line changes only while the clock is low; clock never held
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      cnt_reg <= 4'h0;
      read_reg <= 1'b0;
      sda_oe <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      wr_start <= 1'b0;
      rd_start <= 1'b0;
      tx_load <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      wr_start <= 1'b0;
      rd_start <= 1'b0;
      tx_load <= 1'b0;
      if (start_cond)
      begin
        // start or repeated start
        state_reg <= ST_ADDR;
        cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop_cond)
      begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_ADDR, ST_WRX:
          begin
            if (scl_rise && cnt_reg != 4'h8)
            begin
              shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
              cnt_reg <= cnt_reg + 4'h1;
            end
            else if (scl_fall && cnt_reg == 4'h8)
            begin
              if (state_reg == ST_WRX)
              begin
                // byte complete: hand over and ack
                rx_data <= shift_reg;
                rx_valid <= 1'b1;
                sda_oe <= 1'b1;
                state_reg <= ST_WACK;
              end
              else if (shift_reg[7:1] == own_addr)
              begin
                read_reg <= shift_reg[0];
                rd_start <= shift_reg[0];
                wr_start <= !shift_reg[0];
                sda_oe <= 1'b1;
                state_reg <= ST_AACK;
              end
              else
                state_reg <= ST_IDLE;
            end
          end
          ST_AACK, ST_RNEXT:
          begin
            if (scl_fall)
            begin
              if (read_reg)
              begin
                // first bit of a read byte
                shift_reg <= tx_data;
                sda_oe <= !tx_data[7];
                tx_load <= 1'b1;
                cnt_reg <= 4'h1;
                state_reg <= ST_TX;
              end
              else
              begin
                sda_oe <= 1'b0;
                cnt_reg <= 4'h0;
                state_reg <= ST_WRX;
              end
            end
          end
          ST_WACK:
          begin
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              cnt_reg <= 4'h0;
              state_reg <= ST_WRX;
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (cnt_reg == 4'h8)
              begin
                sda_oe <= 1'b0;
                state_reg <= ST_RACK;
              end
              else
              begin
                sda_oe <= !shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK:
          begin
            // controller ack keeps the read going, nack ends it
            if (scl_rise)
              state_reg <= sda_sync_reg[1] ? ST_IDLE : ST_RNEXT;
          end
          default:
          begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// [testbench/asf_host_model.sv]
// host i2c controller model for the converter status target bench
module asf_host_model (
  input wire logic sda, // bus data wire level
  output logic scl_pull, // high pulls bus clock low
  output logic sda_pull // high pulls bus data low
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime Q = 31.25; // quarter of the 125 ns bit time
  // idle: both lines released to their pull-ups
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // one bit, clock runs only inside frames and never waits on the wire
  task automatic bit_io(input logic b, output logic got);
    sda_pull = !b;
    #Q scl_pull = 1'b0;
    #Q got = sda;
    #Q scl_pull = 1'b1;
    #Q;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start_c();
    sda_pull = 1'b0;
    #Q scl_pull = 1'b0;
    #Q sda_pull = 1'b1;
    #Q scl_pull = 1'b1;
    #Q;
  endtask
  // stop: data rises while clock high, then both lines stand still
  task automatic stop_c();
    sda_pull = 1'b1;
    #Q scl_pull = 1'b0;
    #Q sda_pull = 1'b0;
    #Q;
  endtask
  // byte out msb first, ack sampled on the ninth bit
  task automatic send(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], x);
    bit_io(1'b1, x);
    ack = !x;
  endtask
  // byte in msb first, ack unless this is the last byte
  task automatic recv(input logic more, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(!more, x);
  endtask
endmodule

// [testbench/tb_asf_status_target.sv]
// self-checking bench for the converter status i2c target
module tb_asf_status_target;
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // signals and rows
  // ****
  logic clk, rst, scl, sda, h_scl, h_sda; // clock, reset, wires
  logic sda_out, sda_oe, scl_out, scl_oe; // design bus drives
  logic [1:0] lo, hi; // address strap codes
  logic rv, rdy_out, rdy_oe, p_start, p_pd, p_rst; // pulses, pin
  logic [23:0] rd; // new result value
  logic [7:0] cfg; // configuration contents
  logic [6:0] tgt; // target address in use
  logic bad_drive = 1'b0; // a pin driven high or clock held
  int n_cmd [3] = '{0, 0, 0}; // start, power-down, reset pulses
  int n_mismatch = 0;
  int total_checks = 0;
  typedef struct {logic [1:0] l; logic [1:0] h; logic [23:0] d;} asf_row_t;
  asf_row_t rows [4] = '{'{2'h0, 2'h0, 24'h123456},
    '{2'h3, 2'h1, 24'h800001}, '{2'h2, 2'h3, 24'hfedcba},
    '{2'h1, 2'h2, 24'h00ff00}};
  logic [7:0] cmds [3] = '{8'h08, 8'h02, 8'h06}; // start, sleep, reset
  asf_status_target u_asf_status_target (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
    .scl_oe(scl_oe), .addr_select_pin_low(lo),
    .addr_select_pin_high(hi), .result_valid(rv), .result_data(rd),
    .result_ready_n_out(rdy_out), .result_ready_n_oe(rdy_oe),
    .config_out(cfg), .start_pulse(p_start),
    .powerdown_pulse(p_pd), .soft_reset_pulse(p_rst)
  );
  asf_host_model u_asf_host_model (
    .sda(sda), .scl_pull(h_scl), .sda_pull(h_sda)
  );
  assign scl = !(h_scl | scl_oe); // pulled-up wires
  assign sda = !(h_sda | sda_oe);
  assign tgt = {asf_pkg::ADDR_BASE, hi, lo};
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pin drive watch and command pulse counts
  always @(posedge clk)
  begin
    if (!rst && (scl_oe !== 1'b0 || sda_out !== 1'b0 || rdy_out !== 1'b0
        || scl_out !== 1'b0))
      bad_drive = 1'b1;
    if (p_start === 1'b1)
      n_cmd[0]++;
    if (p_pd === 1'b1)
      n_cmd[1]++;
    if (p_rst === 1'b1)
      n_cmd[2]++;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [23:0] got, exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic do_reset(input logic [1:0] l, h);
    @(negedge clk);
    lo = l;
    hi = h;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // one-cycle new result from the converter
  task automatic pulse(input logic [23:0] d);
    @(negedge clk);
    rv = 1'b1;
    rd = d;
    @(negedge clk);
    rv = 1'b0;
    @(negedge clk);
  endtask
  // command write, optional data byte, optional read after restart
  task automatic xfer(input logic [6:0] a, input logic [7:0] cmd,
    input int n_wr, input logic [7:0] wd, input int n_rd,
    output logic [23:0] got, output logic acked);
    logic ack;
    logic [7:0] b;
    got = 24'h0;
    u_asf_host_model.start_c();
    u_asf_host_model.send({a, 1'b0}, acked);
    if (acked)
    begin
      u_asf_host_model.send(cmd, ack);
      if (n_wr > 0)
        u_asf_host_model.send(wd, ack);
      if (n_rd > 0)
      begin
        u_asf_host_model.start_c();
        u_asf_host_model.send({a, 1'b1}, ack);
        for (int i = 0; i < n_rd; i++)
        begin
          u_asf_host_model.recv(i < n_rd - 1, b);
          got = {got[15:0], b};
        end
      end
    end
    u_asf_host_model.stop_c();
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    logic [23:0] got;
    logic ack;
    rst = 1'b1;
    lo = 2'h0;
    hi = 2'h0;
    rv = 1'b0;
    rd = 24'h0;
    // ordinary rows: strap, status, result, clear
    foreach (rows[k])
    begin
      do_reset(rows[k].l, rows[k].h);
      xfer(tgt, 8'h24, 0, 8'h00, 1, got, ack);
      chk(ack, 1'b1, "address ack");
      chk(got, 24'h0, "status after reset");
      pulse(rows[k].d);
      chk(rdy_oe, 1'b1, "ready pin low");
      xfer(tgt, 8'h24, 0, 8'h00, 1, got, ack);
      chk(got[7], 1'b1, "flag set");
      xfer(tgt, 8'h10, 0, 8'h00, 3, got, ack);
      chk(got, rows[k].d, "result bytes");
      xfer(tgt, 8'h24, 0, 8'h00, 1, got, ack);
      chk(got[7], 1'b0, "flag cleared");
      chk(rdy_oe, 1'b0, "ready pin released");
      done("row");
    end
    xfer(tgt ^ 7'h01, 8'h24, 0, 8'h00, 1, got, ack);
    chk(ack, 1'b0, "foreign address ignored");
    done("foreign address");
    pulse(24'h5a5a5a);
    xfer(tgt, 8'h44, 1, 8'hff, 0, got, ack);
    xfer(tgt, 8'h24, 0, 8'h00, 1, got, ack);
    chk(got, 24'h80, "status after write");
    done("status write");
    fork
      xfer(tgt, 8'h10, 0, 8'h00, 3, got, ack);
      #4500 pulse(24'h0f0f0f);
    join
    chk(got, 24'h5a5a5a, "read during new result");
    xfer(tgt, 8'h24, 0, 8'h00, 1, got, ack);
    chk(got[7], 1'b1, "late result flagged");
    xfer(tgt, 8'h10, 0, 8'h00, 3, got, ack);
    chk(got, 24'h0f0f0f, "late result bytes");
    done("result mid transfer");
    xfer(tgt, 8'h40, 1, 8'h12, 0, got, ack);
    chk(cfg, 8'h12, "config write");
    xfer(tgt, 8'h20, 0, 8'h00, 1, got, ack);
    chk(got, 24'h12, "config read");
    foreach (cmds[k])
    begin
      xfer(tgt, cmds[k], 0, 8'h00, 0, got, ack);
      chk(n_cmd[k][23:0], 24'h1, "command pulse");
    end
    chk(cfg, 8'h00, "config after reset command");
    done("commands");
    pulse(24'h000001);
    do_reset(lo, hi);
    chk(rdy_oe, 1'b0, "ready pin after reset");
    xfer(tgt, 8'h24, 0, 8'h00, 1, got, ack);
    chk(got, 24'h0, "status after mid-run reset");
    chk(bad_drive, 1'b0, "clock held or pin driven high");
    done("mid-run reset");
    summarize();
  end
  // watchdog well beyond the expected run length
  initial
  begin
    #600000;
    n_mismatch++;
    $display("BAD at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
